// [inc/flag_regs_pkg.sv]
package flag_regs_pkg;
    localparam logic [5:0] OFS_FLAG_CLEAR = 6'h1c;
    localparam logic [5:0] OFS_CHECK_VALUE = 6'h20;
    localparam logic [5:0] OFS_RX_BYTE = 6'h24;
    localparam logic [5:0] OFS_TX_BYTE = 6'h28;
    localparam logic [5:0] OFS_STATUS = 6'h2c;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h30;
    localparam logic [5:0] OFS_CONTROL = 6'h34;
    localparam int BIT_ADDR_MATCH = 3;
    localparam int BIT_NO_ACK = 4;
    localparam int BIT_STOP_SEEN = 5;
    localparam int BIT_BUS_ERROR = 8;
    localparam int BIT_ARB_LOSS = 9;
    localparam int BIT_OVER_UNDER = 10;
    localparam int BIT_CHECK_ERROR = 11;
    localparam int BIT_TIMEOUT = 12;
    localparam int BIT_ALERT = 13;
    localparam int BIT_TX_EMPTY = 0;
    localparam int BIT_PERIPH_EN = 0;
    localparam int BIT_CHECK_EN = 1;
    localparam int BIT_START = 2;
    localparam logic [13:0] FLAG_MASK_I2C = 14'h0738;
    localparam logic [13:0] FLAG_MASK_SMB = 14'h3800;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] rx_byte;
        logic rx_valid;
        logic [7:0] check_value;
        logic check_valid;
        logic [13:0] flag_set;
        logic tx_empty_flag;
        logic tx_taken;
    } core_in_s;

    typedef struct packed {
        logic [7:0] tx_byte;
        logic tx_loaded;
        logic start;
        logic peripheral_enable;
        logic check_calc_enable;
    } core_out_s;
endpackage

// [hdl/flag_regs.sv]
`timescale 1ns/1ns
// Function
// R1: Bit 3 clears address match and start
// R2: Bit 4 clears no-ack flag
// R3: Bit 5 clears stop seen flag
// R4: Bit 8 clears bus error flag
// R5: Bit 9 clears arbitration loss flag
// R6: Bit 10 clears overrun/underrun flag
// R7: Bit 11 clears check error flag
// R8: Bit 12 clears timeout flag
// R9: Bit 13 clears alert flag
// R10: Without SMBus, bits 11-13 held zero
// R11: Computed check byte readable when enabled
// R12: Check byte zeroed while peripheral disabled
// R13: Received byte shown in receive register
// R14: Transmit byte writable only when empty
// R15: Flags cleared while peripheral disabled
// R16: Zero bits and unused bits ignored
// R17: Reserved bits read as zero
module flag_regs #(
    parameter bit SMBUS_SUPPORT = 1'b1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire flag_regs_pkg::core_in_s core_i,
    output flag_regs_pkg::core_out_s core_o,
    output logic irq_o
);
    // Access handshake
    logic ack_r;
    logic ack_nxt;
    logic wait_r;
    logic wait_nxt;
    // Status flags, set by the core and cleared by software or disable
    logic [13:0] flags_r;
    logic [13:0] flags_nxt;
    // Interrupt mask, same layout as the status flags
    logic [13:0] mask_r;
    logic [13:0] mask_nxt;
    // Control bits
    logic en_r;
    logic en_nxt;
    logic check_en_r;
    logic check_en_nxt;
    logic start_r;
    logic start_nxt;
    // Packet check byte, held while the check logic is on
    logic [7:0] check_r;
    logic [7:0] check_nxt;
    // Last byte received from the bus
    logic [7:0] rx_r;
    logic [7:0] rx_nxt;
    // Byte waiting to go out, and whether the core still has to take it
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic loaded_r;
    logic loaded_nxt;
    // Registered read data and interrupt level
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    // Clear requests, one per status flag
    logic [13:0] clr_req;
    logic addr_match_clear;
    logic no_ack_clear;
    logic stop_seen_clear;
    logic bus_error_clear;
    logic arb_loss_clear;
    logic over_under_clear;
    logic check_error_clear;
    logic timeout_clear;
    logic alert_clear;
    // Decode shared by all groups
    logic [13:0] impl_mask;
    logic [31:0] lanes;
    logic [13:0] clr;
    logic wr;
    logic rd;
    logic take;

    // Expands byte enables into a bit mask over the data word
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Word decode; the two low address bits select nothing
    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = (a[5:2] == ofs[5:2]);
    endfunction

    // Replaces the byte lanes picked by m and keeps the others
    function automatic logic [13:0] merge14(input logic [13:0] old,
        input logic [31:0] d, input logic [31:0] m);
        merge14 = (old & ~m[13:0]) | (d[13:0] & m[13:0]);
    endfunction

    // Implemented flags; without SMBus the last three stay zero
    always_comb begin
        impl_mask = flag_regs_pkg::FLAG_MASK_I2C;
        if (SMBUS_SUPPORT) begin
            impl_mask = flag_regs_pkg::FLAG_MASK_I2C | flag_regs_pkg::FLAG_MASK_SMB; // [R10]
        end
        // Byte lanes gate every write, clear register included
        lanes = lane_mask(avs_byteenable_i);
        // An access is taken once: ack_r blocks the held request on its second edge
        take = (avs_read_i || avs_write_i) && !ack_r;
        wr = avs_write_i && !ack_r;
        rd = avs_read_i && !ack_r;
    end

    // One wait cycle: the answer stands in the cycle after the request is taken
    // Waitrequest has a flop of its own so the pin sees no gate after the register
    // Read and write are never high together, so one flag covers both
    always_comb begin
        ack_nxt = take;
        wait_nxt = !take;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            // Held high in reset so no access is answered early
            wait_r <= 1'b1;
        end else begin
            ack_r <= ack_nxt;
            wait_r <= wait_nxt;
        end
    end

    always_comb begin
        clr_req = 14'h0000;
        if (wr && hit(avs_address_i, flag_regs_pkg::OFS_FLAG_CLEAR)) begin
            // Only ones clear; zeros and unused positions do nothing [R16]
            clr_req = avs_writedata_i[13:0] & lanes[13:0] & impl_mask;
        end
        addr_match_clear = clr_req[flag_regs_pkg::BIT_ADDR_MATCH]; // [R1]
        no_ack_clear = clr_req[flag_regs_pkg::BIT_NO_ACK]; // [R2]
        stop_seen_clear = clr_req[flag_regs_pkg::BIT_STOP_SEEN]; // [R3]
        bus_error_clear = clr_req[flag_regs_pkg::BIT_BUS_ERROR]; // [R4]
        arb_loss_clear = clr_req[flag_regs_pkg::BIT_ARB_LOSS]; // [R5]
        over_under_clear = clr_req[flag_regs_pkg::BIT_OVER_UNDER]; // [R6]
        check_error_clear = clr_req[flag_regs_pkg::BIT_CHECK_ERROR]; // [R7]
        timeout_clear = clr_req[flag_regs_pkg::BIT_TIMEOUT]; // [R8]
        alert_clear = clr_req[flag_regs_pkg::BIT_ALERT]; // [R9]
    end

    always_comb begin
        clr = 14'h0000;
        clr[flag_regs_pkg::BIT_ADDR_MATCH] = addr_match_clear;
        clr[flag_regs_pkg::BIT_NO_ACK] = no_ack_clear;
        clr[flag_regs_pkg::BIT_STOP_SEEN] = stop_seen_clear;
        clr[flag_regs_pkg::BIT_BUS_ERROR] = bus_error_clear;
        clr[flag_regs_pkg::BIT_ARB_LOSS] = arb_loss_clear;
        clr[flag_regs_pkg::BIT_OVER_UNDER] = over_under_clear;
        clr[flag_regs_pkg::BIT_CHECK_ERROR] = check_error_clear;
        clr[flag_regs_pkg::BIT_TIMEOUT] = timeout_clear;
        clr[flag_regs_pkg::BIT_ALERT] = alert_clear;
        // Hardware set wins over a same-cycle clear, so no event is lost
        flags_nxt = (flags_r & ~clr) | core_i.flag_set; // [R1] [R2] [R3] [R4] [R5] [R6]
        flags_nxt = flags_nxt & impl_mask; // [R7] [R8] [R9] [R10]
        // Disable wins last: flags are dropped even if the core sets one
        if (!en_r) begin
            flags_nxt = 14'h0000; // [R15]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flags_r <= 14'h0000;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Software may write either low byte lane on its own
    always_comb begin
        mask_nxt = mask_r;
        if (wr && hit(avs_address_i, flag_regs_pkg::OFS_IRQ_MASK)) begin
            mask_nxt = merge14(mask_r, avs_writedata_i, lanes);
        end
        // Bits that do not exist stay zero, so they can never raise the line
        mask_nxt = mask_nxt & impl_mask;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mask_r <= 14'h0000;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // Control fields live in the low byte lane only
    always_comb begin
        en_nxt = en_r;
        check_en_nxt = check_en_r;
        start_nxt = start_r;
        if (wr && hit(avs_address_i, flag_regs_pkg::OFS_CONTROL) && avs_byteenable_i[0]) begin
            en_nxt = avs_writedata_i[flag_regs_pkg::BIT_PERIPH_EN];
            check_en_nxt = avs_writedata_i[flag_regs_pkg::BIT_CHECK_EN];
            start_nxt = avs_writedata_i[flag_regs_pkg::BIT_START];
        end
        // Match clear also drops the start request, and wins over a control write
        if (addr_match_clear) begin
            start_nxt = 1'b0; // [R1]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            en_r <= 1'b0;
            check_en_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            check_en_r <= check_en_nxt;
            start_r <= start_nxt;
        end
    end

    // The byte is loaded only while the check logic is on
    always_comb begin
        check_nxt = check_r;
        if (core_i.check_valid && check_en_r) begin
            check_nxt = core_i.check_value; // [R11]
        end
        // Disable wins over a byte from the core in the same cycle
        if (!en_r) begin
            check_nxt = 8'h00; // [R12]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            check_r <= 8'h00;
        end else begin
            check_r <= check_nxt;
        end
    end

    // No receive buffer: a new byte overwrites one that was never read
    always_comb begin
        rx_nxt = rx_r;
        if (core_i.rx_valid) begin
            rx_nxt = core_i.rx_byte; // [R13]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rx_r <= 8'h00;
        end else begin
            rx_r <= rx_nxt;
        end
    end

    // A refused write is still answered, so software checks the empty flag first
    always_comb begin
        tx_nxt = tx_r;
        loaded_nxt = loaded_r && !core_i.tx_taken;
        if (wr && hit(avs_address_i, flag_regs_pkg::OFS_TX_BYTE) && avs_byteenable_i[0]
            && core_i.tx_empty_flag) begin
            tx_nxt = avs_writedata_i[7:0]; // [R14]
            loaded_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_r <= 8'h00;
            loaded_r <= 1'b0;
        end else begin
            tx_r <= tx_nxt;
            loaded_r <= loaded_nxt;
        end
    end

    // Read data is loaded on the taking edge and then holds until the next read
    // Unmapped words read as zero and ignore writes
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd) begin
            rdata_nxt = flag_regs_pkg::RESET_WORD; // [R17]
            if (hit(avs_address_i, flag_regs_pkg::OFS_CHECK_VALUE)) begin
                rdata_nxt[7:0] = check_en_r ? check_r : 8'h00; // [R11]
            end else if (hit(avs_address_i, flag_regs_pkg::OFS_RX_BYTE)) begin
                rdata_nxt[7:0] = rx_r; // [R13]
            end else if (hit(avs_address_i, flag_regs_pkg::OFS_TX_BYTE)) begin
                rdata_nxt[7:0] = tx_r; // [R14]
            end else if (hit(avs_address_i, flag_regs_pkg::OFS_STATUS)) begin
                rdata_nxt[13:0] = flags_r;
                // Bit 0 shows the live empty flag, not a stored copy
                rdata_nxt[flag_regs_pkg::BIT_TX_EMPTY] = core_i.tx_empty_flag;
            end else if (hit(avs_address_i, flag_regs_pkg::OFS_IRQ_MASK)) begin
                rdata_nxt[13:0] = mask_r;
            end else if (hit(avs_address_i, flag_regs_pkg::OFS_CONTROL)) begin
                rdata_nxt[flag_regs_pkg::BIT_PERIPH_EN] = en_r;
                rdata_nxt[flag_regs_pkg::BIT_CHECK_EN] = check_en_r;
                rdata_nxt[flag_regs_pkg::BIT_START] = start_r;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Level interrupt from the next values, so it follows the flags without lag
    // Masked flags stay visible in status but keep the line low
    always_comb begin
        irq_nxt = |(flags_nxt & mask_nxt);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // Every output is taken straight from a flop
    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o = rdata_r;
    assign irq_o = irq_r;
    assign core_o.tx_byte = tx_r;
    assign core_o.tx_loaded = loaded_r;
    assign core_o.start = start_r;
    assign core_o.peripheral_enable = en_r;
    assign core_o.check_calc_enable = check_en_r;
endmodule

// [sim/flag_regs_sva.sv]
`timescale 1ns/1ns
module flag_regs_sva (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire flag_regs_pkg::core_in_s core_i,
    input wire flag_regs_pkg::core_out_s core_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // An access is taken only while waitrequest is still high
    wire tk = avs_waitrequest_o && (avs_read_i || avs_write_i);
    wire rd = tk && avs_read_i;
    wire wr = tk && avs_write_i && avs_byteenable_i[0];
    sequence s_rx_then_read;
        core_i.rx_valid ##1 (rd && avs_address_i == 6'h24);
    endsequence
    a_ack_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    a_req_answered: assert property (tk |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    a_start_cleared: assert property (wr && avs_address_i == 6'h1c && avs_writedata_i[3]
        |=> !core_o.start)
        else $error("start not cleared by match clear");
    a_tx_loaded: assert property (wr && avs_address_i == 6'h28 && core_i.tx_empty_flag
        |=> core_o.tx_byte == $past(avs_writedata_i[7:0]))
        else $error("transmit byte not loaded");
    a_tx_refused: assert property (wr && avs_address_i == 6'h28 && !core_i.tx_empty_flag
        |=> $stable(core_o.tx_byte))
        else $error("transmit byte changed while full");
    a_rx_shown: assert property (s_rx_then_read
        |=> avs_readdata_o == {24'h00_0000, $past(core_i.rx_byte, 2)})
        else $error("received byte not shown");
    a_clear_reads_zero: assert property (rd && avs_address_i == 6'h1c |=> avs_readdata_o == 32'h0000_0000)
        else $error("clear register read not zero");
    a_check_off_zero: assert property (rd && avs_address_i == 6'h20 && !core_o.peripheral_enable
        |=> avs_readdata_o == 32'h0000_0000)
        else $error("check value not zero while disabled");
    a_check_upper_zero: assert property (rd && avs_address_i == 6'h20
        |=> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("check register upper bits not zero");
endmodule
bind flag_regs flag_regs_sva i_flag_regs_sva (.*);

// [sim/core_model.sv]
`timescale 1ns/1ns
module core_model (
    input wire logic clock_i,
    input wire flag_regs_pkg::core_out_s ctl_i,
    output flag_regs_pkg::core_in_s drv_o
);
    initial drv_o = '0;
    // Takes each loaded byte at once, as a prompt bus would
    always @(posedge clock_i) drv_o.tx_taken <= ctl_i.tx_loaded && !drv_o.tx_taken;
    task automatic pulse(input logic [13:0] f, input logic [7:0] rb, input logic [7:0] cv);
        @(posedge clock_i);
        drv_o.flag_set <= f;
        drv_o.rx_byte <= rb;
        drv_o.check_value <= cv;
        {drv_o.rx_valid, drv_o.check_valid} <= 2'h3;
        @(posedge clock_i);
        drv_o.flag_set <= 14'h0000;
        {drv_o.rx_valid, drv_o.check_valid} <= 2'h0;
    endtask
endmodule

// [sim/flag_regs_bench.sv]
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module flag_regs_bench;
    logic clock_i = 0, rst_i = 1, rd = 0, wr = 0, wt, irq;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0000_0000, rdata, q;
    flag_regs_pkg::core_in_s cin;
    flag_regs_pkg::core_out_s cout;
    int mismatches = 0, compares = 0, cyc = 0, flags = 0, rxb = 0, cv = 0, b;
    int bits[9] = '{3, 4, 5, 8, 9, 10, 11, 12, 13};
    flag_regs i_flag_regs (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .core_i(cin), .core_o(cout), .irq_o(irq));
    core_model i_core_model (.clock_i(clock_i), .ctl_i(cout), .drv_o(cin));
    initial forever #5 clock_i = ~clock_i;
    always @(posedge clock_i) if (++cyc == 3000) begin mismatches++; close_out(); end
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clock_i); while (wt !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rdchk(input logic [5:0] a, input int e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK($sformatf("reg %h", a), 32'(e), q)
    endtask
    task automatic burst;
        rxb = $urandom & 255;
        cv = $urandom & 255;
        i_core_model.pulse(14'h3f38, rxb[7:0], cv[7:0]);
        flags = 'h3f38;
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        b = $urandom(32'h1e76);
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        i_core_model.drv_o.tx_empty_flag <= 1'b1;
        @(posedge clock_i);
        rdchk(6'h24, 0);
        rdchk(6'h20, 0);
        $display("reset values done");
        bus(1'b1, 6'h34, 32'h0000_0007);
        bus(1'b1, 6'h30, 32'h0000_3f38);
        burst();
        rdchk(6'h24, rxb);
        rdchk(6'h20, cv);
        `CHK("irq", 1'b1, irq)
        foreach (bits[i]) begin
            bus(1'b1, 6'h1c, (32'h1 << bits[i]) | ($urandom & 32'hffff_c0c7));
            flags &= ~(1 << bits[i]);
            rdchk(6'h2c, flags | 1);
        end
        rdchk(6'h34, 3);
        `CHK("irq", 1'b0, irq)
        $display("flag clear done");
        burst();
        bus(1'b1, 6'h30, 32'h0000_0000);
        rdchk(6'h2c, flags | 1);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, 6'h34, 32'h0000_0000);
        rdchk(6'h2c, 1);
        rdchk(6'h20, 0);
        bus(1'b1, 6'h34, 32'h0000_0003);
        rdchk(6'h20, 0);
        $display("disable done");
        b = $urandom & 255;
        bus(1'b1, 6'h28, b);
        `CHK("tx out", b[7:0], cout.tx_byte)
        rdchk(6'h28, b);
        i_core_model.drv_o.tx_empty_flag <= 1'b0;
        bus(1'b1, 6'h28, ~b);
        rdchk(6'h28, b);
        rdchk(6'h3c, 0);
        rdchk(6'h1c, 0);
        $display("transmit and reserved done");
        close_out();
    end
endmodule
